// ==== design/output_status_fault_indication.sv ====
`timescale 1ns/100ps
module output_status_fault_indication
  import io_status_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  io_link_if.device link,
  input wire logic inserted_pin,
  input wire logic [SLICES-1:0][NUM_CH*STATE_W-1:0] slice_state,
  input wire logic [SLICES-1:0] slice_fault,
  input wire logic [NUM_CH*MEAS_W-1:0] meas_volt,
  input wire logic [NUM_CH*MEAS_W-1:0] meas_curr,
  output logic [NUM_CH-1:0] out_energise,
  output logic [NUM_CH*2-1:0] chan_led,
  output logic [SLICES*2-1:0] health_led,
  output logic [1:0] active_led,
  output logic [1:0] standby_led,
  output logic [1:0] educated_led
);

  // ==========================================
  // Insertion switch synchroniser
  logic ins_meta;
  logic inserted;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ins_meta <= 1'b0;
      inserted <= 1'b0;
    end else begin
      ins_meta <= inserted_pin;
      inserted <= ins_meta;
    end
  end

  // ==========================================
  // Shared blink timebase
  logic [31:0] blink_cnt;
  logic blink;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt <= 32'h0;
      blink <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      blink_cnt <= 32'h0;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // ==========================================
  // Link access decode
  logic [2:0] cmd;
  logic [TABLE_W-1:0] ind_table;
  logic [NUM_CH-1:0] demand;
  logic [5:0] ch_idx;

  assign ch_idx = link.addr[5:0];

  always_comb begin
    cmd = 3'h0;
    if (link.req && link.we && link.addr == LREG_COMMAND) begin
      cmd = link.wdata[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_table <= TABLE_RESET;
      demand <= '0;
    end else if (link.req && link.we) begin
      if (link.addr == LREG_TABLE) begin
        ind_table <= link.wdata[TABLE_W-1:0];
      end
      if (link.addr == LREG_DEMAND_LO) begin
        demand[31:0] <= link.wdata;
      end
      if (link.addr == LREG_DEMAND_HI) begin
        demand[NUM_CH-1:32] <= link.wdata[NUM_CH-33:0];
      end
    end
  end

  // ==========================================
  // Module mode
  module_mode_t mode;
  logic educated;
  logic [1:0] fault_count;
  logic double_fault;

  assign fault_count = 2'(slice_fault[0]) + 2'(slice_fault[1]) + 2'(slice_fault[2]);
  assign double_fault = fault_count >= 2'h2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_ABSENT;
    end else if (!inserted) begin
      mode <= MODE_ABSENT;
    end else begin
      unique case (mode)
        MODE_ABSENT: mode <= MODE_CONFIG;
        MODE_CONFIG: begin
          if (double_fault) begin
            mode <= MODE_SHUTDOWN;
          end else if (cmd == CMD_RELEASE && educated) begin
            mode <= MODE_ACTIVE;
          end
        end
        MODE_STANDBY: begin
          if (double_fault) begin
            mode <= MODE_SHUTDOWN;
          end else if (cmd == CMD_ACTIVATE) begin
            mode <= MODE_ACTIVE;
          end
        end
        MODE_ACTIVE: begin
          if (double_fault) begin
            mode <= MODE_SHUTDOWN;
          end else if (cmd == CMD_MAINTAIN) begin
            mode <= MODE_MAINTAIN;
          end else if (cmd == CMD_STANDBY) begin
            mode <= MODE_STANDBY;
          end
        end
        MODE_MAINTAIN: begin
          if (double_fault) begin
            mode <= MODE_SHUTDOWN;
          end else if (cmd == CMD_ACTIVATE) begin
            mode <= MODE_ACTIVE;
          end else if (cmd == CMD_STANDBY) begin
            mode <= MODE_STANDBY;
          end
        end
        MODE_SHUTDOWN: mode <= MODE_SHUTDOWN;
        default: mode <= MODE_ABSENT;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      educated <= 1'b0;
    end else if (!inserted) begin
      educated <= 1'b0;
    end else if (cmd == CMD_EDUCATE && mode != MODE_SHUTDOWN) begin
      educated <= 1'b1;
    end
  end

  // ==========================================
  // Channel vote, short latch and line fault
  logic [NUM_CH*STATE_W-1:0] voted;
  logic [NUM_CH-1:0] short_latched;
  logic [NUM_CH-1:0] line_fault;
  logic [NUM_CH*STATE_W-1:0] reported;
  logic energised;

  assign voted = maj3(slice_state[0], slice_state[1], slice_state[2]);
  assign energised = mode == MODE_ACTIVE || mode == MODE_MAINTAIN;

  // Each channel looks only at its own voted bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_latched <= '0;
      line_fault <= '0;
      reported <= '0;
      out_energise <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (voted[i*STATE_W +: STATE_W] == ST_SHORT) begin
          short_latched[i] <= 1'b1;
        end else if (!demand[i]) begin
          short_latched[i] <= 1'b0;
        end
        line_fault[i] <= voted[i*STATE_W +: STATE_W] >= ST_OPEN || short_latched[i];
        reported[i*STATE_W +: STATE_W] <= short_latched[i] ? ST_SHORT : voted[i*STATE_W +: STATE_W];
        out_energise[i] <= energised && demand[i] && !short_latched[i] &&
          voted[i*STATE_W +: STATE_W] != ST_SHORT;
      end
    end
  end

  // ==========================================
  // Indicators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_led <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reported[i*STATE_W +: STATE_W] > ST_FAULT) begin
          chan_led[i*2 +: 2] <= ind_color(IND_FLASH_RED, blink);
        end else begin
          chan_led[i*2 +: 2] <= ind_color(ind_t'(ind_table[reported[i*STATE_W +: STATE_W]*3 +: 3]),
            blink);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      health_led <= '0;
    end else begin
      for (int s = 0; s < SLICES; s++) begin
        if (mode == MODE_ABSENT) begin
          health_led[s*2 +: 2] <= LED_OFF;
        end else if (mode == MODE_SHUTDOWN) begin
          health_led[s*2 +: 2] <= LED_RED;
        end else if (slice_fault[s]) begin
          health_led[s*2 +: 2] <= ind_color(IND_FLASH_RED, blink);
        end else begin
          health_led[s*2 +: 2] <= LED_GREEN;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_led <= LED_OFF;
      standby_led <= LED_OFF;
      educated_led <= LED_OFF;
    end else begin
      if (mode == MODE_SHUTDOWN) begin
        active_led <= ind_color(IND_FLASH_RED, blink);
      end else if (energised) begin
        active_led <= LED_GREEN;
      end else if (mode == MODE_CONFIG && educated) begin
        active_led <= ind_color(IND_FLASH_RED, blink);
      end else begin
        active_led <= LED_OFF;
      end
      if (mode == MODE_SHUTDOWN) begin
        standby_led <= ind_color(IND_FLASH_RED, blink);
      end else begin
        standby_led <= mode == MODE_STANDBY ? LED_GREEN : LED_OFF;
      end
      if (mode == MODE_SHUTDOWN || mode == MODE_MAINTAIN) begin
        educated_led <= ind_color(IND_FLASH_AMBER, blink);
      end else begin
        educated_led <= educated ? LED_GREEN : LED_OFF;
      end
    end
  end

  // ==========================================
  // Link read answer
  logic [31:0] module_word_a_word;
  logic [31:0] housekeeping_word;

  assign module_word_a_word = {22'h0, mode == MODE_MAINTAIN, educated, mode == MODE_SHUTDOWN, slice_fault, 1'b0, mode};
  assign housekeeping_word = {28'h0, |line_fault, fault_count, |slice_fault};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.ack <= 1'b0;
      link.rdata <= 32'h0;
    end else begin
      link.ack <= link.req;
      link.rdata <= 32'h0;
      if (link.req && !link.we) begin
        if (link.addr[7:6] == LREG_STATE_PAGE && ch_idx < 6'(NUM_CH)) begin
          link.rdata <= {29'h0, reported[ch_idx*STATE_W +: STATE_W]};
        end else if (link.addr[7:6] == LREG_MEAS_PAGE && ch_idx < 6'(NUM_CH)) begin
          link.rdata <= {meas_volt[ch_idx*MEAS_W +: MEAS_W], meas_curr[ch_idx*MEAS_W +: MEAS_W]};
        end else begin
          unique case (link.addr)
            LREG_MODE: link.rdata <= {29'h0, mode};
            LREG_MODULE_WORD_A: link.rdata <= module_word_a_word;
            LREG_HOUSEKEEPING: link.rdata <= housekeeping_word;
            LREG_TABLE: link.rdata <= {17'h0, ind_table};
            LREG_DEMAND_LO: link.rdata <= demand[31:0];
            LREG_DEMAND_HI: link.rdata <= {24'h0, demand[NUM_CH-1:32]};
            LREG_FAULT_LO: link.rdata <= line_fault[31:0];
            LREG_FAULT_HI: link.rdata <= {24'h0, line_fault[NUM_CH-1:32]};
            default: link.rdata <= 32'h0;
          endcase
        end
      end
    end
  end

  assign link.mode = mode;
  assign link.fault = |slice_fault;

endmodule // output_status_fault_indication

// ==== design/io_status_pkg.sv ====
// Summary of operation
// - One status indicator per output channel
// - Vote indicator data bits two of three
// - Per-state table selects channel indicator mode
// - Default table: off, green, flashing, red
// - Short circuit latches channel off, reported
// - Wiring fault sets mode, state, line fault
// - Channel faults never disturb other channels
// - Cleared fault restores plain on/off display
// - Channel voltage and current are readable
// - Health green; faulted slice flashes red
// - Faults shown in module_word_a and housekeeping words
// - One slice fault keeps outputs running
// - Shutdown indicator pattern: red, flashing, amber
// - Only removal and reinsertion leaves shutdown
// - Insert, await education, educated green
// - Outputs energise only after release command
// - Active fault transfers to hot standby
// - Without spare, active module keeps control
// - Mode codes zero to five as listed
// - Changeover flashes educated indicator amber
package io_status_pkg;
  localparam int NUM_CH = 40;
  localparam int SLICES = 3;
  localparam int STATE_W = 3;
  localparam int MEAS_W = 16;
  localparam int TABLE_W = 15;
  localparam int LADDR_W = 8;

  typedef enum logic [2:0] {
    MODE_ABSENT = 3'h0,
    MODE_CONFIG = 3'h1,
    MODE_STANDBY = 3'h2,
    MODE_ACTIVE = 3'h3,
    MODE_MAINTAIN = 3'h4,
    MODE_SHUTDOWN = 3'h5
  } module_mode_t;

  typedef enum logic [2:0] {
    IND_OFF = 3'h0,
    IND_GREEN = 3'h1,
    IND_RED = 3'h2,
    IND_FLASH_GREEN = 3'h3,
    IND_FLASH_RED = 3'h4,
    IND_AMBER = 3'h5,
    IND_FLASH_AMBER = 3'h6
  } ind_t;

  // Channel numeric output states
  localparam logic [2:0] ST_OFF = 3'h0;
  localparam logic [2:0] ST_ON = 3'h1;
  localparam logic [2:0] ST_OPEN = 3'h2;
  localparam logic [2:0] ST_SHORT = 3'h3;
  localparam logic [2:0] ST_FAULT = 3'h4;

  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED = 2'h2;
  localparam logic [1:0] LED_AMBER = 2'h3;

  localparam logic [TABLE_W-1:0] TABLE_RESET = 15'h44C8;

  localparam logic [2:0] CMD_EDUCATE = 3'h1;
  localparam logic [2:0] CMD_RELEASE = 3'h2;
  localparam logic [2:0] CMD_STANDBY = 3'h3;
  localparam logic [2:0] CMD_MAINTAIN = 3'h4;
  localparam logic [2:0] CMD_ACTIVATE = 3'h5;

  // Device registers on the link
  localparam logic [7:0] LREG_COMMAND = 8'h00;
  localparam logic [7:0] LREG_MODE = 8'h01;
  localparam logic [7:0] LREG_MODULE_WORD_A = 8'h02;
  localparam logic [7:0] LREG_HOUSEKEEPING = 8'h03;
  localparam logic [7:0] LREG_TABLE = 8'h04;
  localparam logic [7:0] LREG_DEMAND_LO = 8'h05;
  localparam logic [7:0] LREG_DEMAND_HI = 8'h06;
  localparam logic [7:0] LREG_FAULT_LO = 8'h07;
  localparam logic [7:0] LREG_FAULT_HI = 8'h08;
  localparam logic [1:0] LREG_STATE_PAGE = 2'h1;
  localparam logic [1:0] LREG_MEAS_PAGE = 2'h2;

  // Controller registers on AXI4-Lite
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_LINK_GO = 8'h04;
  localparam logic [7:0] HREG_LINK_WDATA = 8'h08;
  localparam logic [7:0] HREG_LINK_RDATA = 8'h0C;
  localparam logic [7:0] HREG_STATUS = 8'h10;
  localparam int GO_TARGET_BIT = 31;
  localparam int GO_WE_BIT = 30;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ = 250;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;

  function automatic logic [NUM_CH*STATE_W-1:0] maj3(input logic [NUM_CH*STATE_W-1:0] a,
      input logic [NUM_CH*STATE_W-1:0] b, input logic [NUM_CH*STATE_W-1:0] c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [1:0] ind_color(input ind_t ind, input logic blink);
    case (ind)
      IND_GREEN: return LED_GREEN;
      IND_RED: return LED_RED;
      IND_AMBER: return LED_AMBER;
      IND_FLASH_GREEN: return blink ? LED_GREEN : LED_OFF;
      IND_FLASH_RED: return blink ? LED_RED : LED_OFF;
      IND_FLASH_AMBER: return blink ? LED_AMBER : LED_OFF;
      default: return LED_OFF;
    endcase
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// ==== design/io_link_if.sv ====
`timescale 1ns/100ps
interface io_link_if;
  import io_status_pkg::*;
  logic req;
  logic we;
  logic [LADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  logic [2:0] mode;
  logic fault;

  modport device (input req, input we, input addr, input wdata,
    output ack, output rdata, output mode, output fault);
  modport host (output req, output we, output addr, output wdata,
    input ack, input rdata, input mode, input fault);
endinterface

// ==== design/io_processor_end.sv ====
`timescale 1ns/100ps
module io_processor_end
  import io_status_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  io_link_if.host link_a,
  io_link_if.host link_b
);

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_WAIT = 2'b01
  } eng_t;

  // ==========================================
  // AXI4-Lite write channel
  logic aw_held;
  logic w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] strb_q;
  logic do_write;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h0;
      w_q <= 32'h0;
      strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
        strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == HREG_CTRL || aw_q == HREG_LINK_GO || aw_q == HREG_LINK_WDATA) ?
          RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Controller registers and link engine
  logic [31:0] ctrl;
  logic [31:0] go_q;
  logic [31:0] link_wdata;
  logic [31:0] link_rdata;
  logic sw_pending;
  eng_t state;
  logic auto_run;
  logic [1:0] step;
  logic active_is_b;
  logic tgt;
  logic req_q;
  logic we_q;
  logic [7:0] addr_q;
  logic [31:0] wdata_q;
  logic act_fault;
  logic [2:0] act_mode;
  logic [2:0] spare_mode;
  logic auto_fire;
  logic tgt_ack;

  assign act_fault = active_is_b ? link_b.fault : link_a.fault;
  assign act_mode = active_is_b ? link_b.mode : link_a.mode;
  assign spare_mode = active_is_b ? link_a.mode : link_b.mode;
  // Without a standby spare nothing fires and the active end keeps control
  assign auto_fire = ctrl[0] && act_fault && act_mode == MODE_ACTIVE && spare_mode == MODE_STANDBY;
  assign tgt_ack = tgt ? link_b.ack : link_a.ack;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= 32'h0;
      link_wdata <= 32'h0;
    end else if (do_write) begin
      if (aw_q == HREG_CTRL) begin
        ctrl <= merge_strb(ctrl, w_q, strb_q);
      end
      if (aw_q == HREG_LINK_WDATA) begin
        link_wdata <= merge_strb(link_wdata, w_q, strb_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ENG_IDLE;
      sw_pending <= 1'b0;
      go_q <= 32'h0;
      auto_run <= 1'b0;
      step <= 2'h0;
      active_is_b <= 1'b0;
      tgt <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 8'h0;
      wdata_q <= 32'h0;
      link_rdata <= 32'h0;
    end else begin
      req_q <= 1'b0;
      if (do_write && aw_q == HREG_LINK_GO && !sw_pending && state == ENG_IDLE) begin
        sw_pending <= 1'b1;
        go_q <= merge_strb(go_q, w_q, strb_q);
      end
      unique case (state)
        ENG_IDLE: begin
          if (auto_fire) begin
            auto_run <= 1'b1;
            step <= 2'h0;
            req_q <= 1'b1;
            tgt <= active_is_b;
            we_q <= 1'b1;
            addr_q <= LREG_COMMAND;
            wdata_q <= {29'h0, CMD_MAINTAIN};
            state <= ENG_WAIT;
          end else if (sw_pending) begin
            sw_pending <= 1'b0;
            req_q <= 1'b1;
            tgt <= go_q[GO_TARGET_BIT];
            we_q <= go_q[GO_WE_BIT];
            addr_q <= go_q[7:0];
            wdata_q <= link_wdata;
            state <= ENG_WAIT;
          end
        end
        ENG_WAIT: begin
          if (tgt_ack) begin
            link_rdata <= tgt ? link_b.rdata : link_a.rdata;
            state <= ENG_IDLE;
            if (auto_run) begin
              if (step == 2'h2) begin
                auto_run <= 1'b0;
                active_is_b <= ~active_is_b;
              end else begin
                step <= step + 2'h1;
                req_q <= 1'b1;
                tgt <= step == 2'h0 ? ~active_is_b : active_is_b;
                wdata_q <= {29'h0, step == 2'h0 ? CMD_ACTIVATE : CMD_STANDBY};
                state <= ENG_WAIT;
              end
            end
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  assign link_a.req = req_q && !tgt;
  assign link_b.req = req_q && tgt;
  assign link_a.we = we_q;
  assign link_b.we = we_q;
  assign link_a.addr = addr_q;
  assign link_b.addr = addr_q;
  assign link_a.wdata = wdata_q;
  assign link_b.wdata = wdata_q;

  // ==========================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        HREG_CTRL: s_axi_rdata <= ctrl;
        HREG_LINK_GO: s_axi_rdata <= go_q;
        HREG_LINK_WDATA: s_axi_rdata <= link_wdata;
        HREG_LINK_RDATA: s_axi_rdata <= link_rdata;
        HREG_STATUS: s_axi_rdata <= {21'h0, link_b.fault, link_a.fault, auto_run,
          state != ENG_IDLE || sw_pending, active_is_b, link_b.mode, link_a.mode};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // io_processor_end

// ==== test/link_checker.sv ====
`timescale 1ns/100ps
module link_checker
  import io_status_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [LADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire logic [2:0] mode,
  input wire logic fault
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================
  // Command in a given mode
  sequence cmd_in_s(logic [2:0] c, logic [2:0] m);
    req && we && addr == LREG_COMMAND && wdata[2:0] == c && mode == m;
  endsequence
  ack_one_cycle_a: assert property (req |=> ack && !req)
    else $error("ack late");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without req");
  rdata_idle_a: assert property (!ack |-> rdata == 32'h0)
    else $error("rdata not idle");
  mode_range_a: assert property (mode <= 3'h5)
    else $error("bad mode");
  shutdown_hold_a: assert property (mode == MODE_SHUTDOWN |=> mode inside {MODE_SHUTDOWN, MODE_ABSENT})
    else $error("shutdown left");
  release_only_a: assert property (($past(mode) == MODE_CONFIG && mode == MODE_ACTIVE)
    |-> $past(req && we && wdata[2:0] == CMD_RELEASE))
    else $error("no release");
  maintain_cmd_a: assert property (cmd_in_s(CMD_MAINTAIN, MODE_ACTIVE) |=> mode == MODE_MAINTAIN)
    else $error("maintain not entered");
  activate_cmd_a: assert property (cmd_in_s(CMD_ACTIVATE, MODE_STANDBY) |=> mode == MODE_ACTIVE)
    else $error("activate not entered");
  standby_cmd_a: assert property (cmd_in_s(CMD_STANDBY, MODE_ACTIVE) |=> mode == MODE_STANDBY)
    else $error("standby not entered");
endmodule // link_checker

// ==== test/output_status_fault_indication_test.sv ====
`timescale 1ns/100ps
module output_status_fault_indication_test
  import io_status_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, active_led, standby_led, educated_led;
  logic inserted_pin;
  logic [SLICES-1:0][NUM_CH*STATE_W-1:0] slice_state;
  logic [SLICES-1:0] slice_fault;
  logic [NUM_CH*MEAS_W-1:0] meas_volt, meas_curr;
  logic [NUM_CH-1:0] out_energise;
  logic [NUM_CH*2-1:0] chan_led;
  logic [SLICES*2-1:0] health_led;
  logic [2:0] hs;
  int fails = 0;
  int total_checks = 0;
  logic [2:0] cmds [4] = '{CMD_MAINTAIN, CMD_ACTIVATE, CMD_STANDBY, CMD_ACTIVATE};
  logic [2:0] modes [4] = '{MODE_MAINTAIN, MODE_ACTIVE, MODE_STANDBY, MODE_ACTIVE};
  io_link_if link_a();
  io_link_if link_b();
  always #2 aclk = ~aclk;
  io_processor_end u_io_processor_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_a(link_a), .link_b(link_b));
  output_status_fault_indication #(.BLINK_CYCLES(4)) u_output_status_fault_indication (.aclk(aclk),
    .aresetn(aresetn), .link(link_a), .inserted_pin(inserted_pin), .slice_state(slice_state),
    .slice_fault(slice_fault), .meas_volt(meas_volt), .meas_curr(meas_curr), .out_energise(out_energise),
    .chan_led(chan_led), .health_led(health_led), .active_led(active_led), .standby_led(standby_led),
    .educated_led(educated_led));
  output_status_fault_indication #(.BLINK_CYCLES(4)) u_output_status_fault_indication_b (.aclk(aclk),
    .aresetn(aresetn), .link(link_b), .inserted_pin(inserted_pin), .slice_state(slice_state),
    .slice_fault(slice_fault), .meas_volt(meas_volt), .meas_curr(meas_curr), .out_energise(),
    .chan_led(), .health_led(), .active_led(), .standby_led(), .educated_led());
  link_checker u_link_checker (.aclk(aclk), .aresetn(aresetn), .req(link_a.req), .we(link_a.we),
    .addr(link_a.addr), .wdata(link_a.wdata), .ack(link_a.ack), .rdata(link_a.rdata),
    .mode(link_a.mode), .fault(link_a.fault));
  // ==========================
  // Access tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = {awready && awvalid, wready && wvalid, bvalid};
      rsp = bresp;
      @(posedge aclk);
      if (hs[2]) awvalid <= 1'b0;
      if (hs[1]) wvalid <= 1'b0;
    end while (!hs[0]);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = {arready && arvalid, 1'b0, rvalid};
      d = rdata;
      @(posedge aclk);
      if (hs[2]) arvalid <= 1'b0;
    end while (!hs[0]);
    rready <= 1'b0;
  endtask
  task automatic lnk(input logic [31:0] go, input logic [31:0] d);
    axw(HREG_LINK_WDATA, d);
    axw(HREG_LINK_GO, go);
    repeat (4) @(posedge aclk);
    do axr(HREG_STATUS, q); while (q[7]);
    axr(HREG_LINK_RDATA, q);
  endtask
  task automatic st(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
    slice_state[0] <= {117'h0, a} << 15;
    slice_state[1] <= {117'h0, b} << 15;
    slice_state[2] <= {117'h0, c} << 15;
    repeat (6) @(posedge aclk);
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================
  // Tests
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, inserted_pin, slice_fault} = '0;
    {awaddr, araddr, wdata, slice_state, meas_volt, meas_curr} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    inserted_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    axr(HREG_STATUS, q);
    chk("mode", 64'h09, q[5:0]);
    axw(8'h20, 32'h0);
    chk("bresp", RESP_SLVERR, rsp);
    lnk(32'h4000_0000, CMD_EDUCATE);
    chk("edu_led", LED_GREEN, educated_led);
    chk("energ", 64'h0, out_energise);
    lnk(32'h4000_0000, CMD_RELEASE);
    chk("act_led", LED_GREEN, active_led);
    for (int i = 0; i < 4; i++) begin
      lnk(32'h4000_0000, cmds[i]);
      axr(HREG_STATUS, q);
      chk("mode_a", modes[i], q[2:0]);
    end
    lnk(32'h0000_0004, 0);
    chk("table", 64'h44C8, q);
    lnk(32'h4000_0005, 32'h20);
    st(ST_ON, ST_ON, ST_SHORT);
    chk("energ", 64'h20, out_energise);
    chk("led5", LED_GREEN, chan_led[11:10]);
    slice_fault <= 3'b010;
    st(ST_SHORT, ST_SHORT, ST_ON);
    chk("led5", LED_RED, chan_led[11:10]);
    chk("energ", 64'h0, out_energise);
    chk("health", {LED_GREEN, 2'h0, LED_GREEN}, {health_led[5:4], 2'h0, health_led[1:0]});
    lnk(32'h0000_0007, 0);
    chk("lfault", 64'h20, q);
    lnk(32'h0000_0002, 0);
    chk("module_word_a", 64'h2, q[6:4]);
    lnk(32'h0000_0003, 0);
    chk("hkeep", 64'h1, q[0]);
    lnk(32'h4000_0005, 32'h0);
    st(ST_OFF, ST_OFF, ST_OFF);
    lnk(32'h0000_0007, 0);
    chk("lfault", 64'h0, q);
    chk("led5", LED_OFF, chan_led[11:10]);
    meas_volt <= 640'h1234 << 80;
    meas_curr <= 640'hABCD << 80;
    lnk(32'h0000_0085, 0);
    chk("meas", 64'h1234ABCD, q);
    slice_fault <= 3'b011;
    repeat (6) @(posedge aclk);
    chk("health", 64'h2A, health_led);
    lnk(32'h4000_0000, CMD_RELEASE);
    axr(HREG_STATUS, q);
    chk("mode_a", MODE_SHUTDOWN, q[2:0]);
    inserted_pin <= 1'b0;
    slice_fault <= 3'b000;
    repeat (6) @(posedge aclk);
    inserted_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    axr(HREG_STATUS, q);
    chk("mode_a", MODE_CONFIG, q[2:0]);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
endmodule // output_status_fault_indication_test
